//--- tps_pkg.sv
package tps_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_TICK_COUNT  = 12'h004;
   localparam logic [9:0]  IDX_OPTION       = 10'h081;
   localparam logic [11:0] ADDR_OPTION      = {IDX_OPTION, 2'h0};
   localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h010;
   localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h014;
   localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h018;
   localparam logic [11:0] ADDR_CONTROL     = 12'h01C;
   localparam logic [11:0] ADDR_WDT_STATUS  = 12'h020;

   // ---------------------------------------------------------------
   // option_control fields and reset values
   // ---------------------------------------------------------------
   localparam int          OPT_SRC_POS     = 5;
   localparam int          OPT_EDGE_POS    = 4;
   localparam int          OPT_ASSIGN_POS  = 3;
   localparam int          OPT_RATIO_LSB   = 0;
   localparam logic [7:0]  OPTION_RESET    = 8'hFF;
   localparam logic [7:0]  TICK_RESET      = 8'h00;
   localparam logic [1:0]  CONTROL_RESET   = 2'h0;
   localparam int          CTRL_SLEEP_POS  = 0;
   localparam int          CTRL_CLEAR_WATCHDOG_INSTR_POS = 1;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_HZ          = 200_000_000;
   localparam int          INSTR_NS        = 200;
   localparam int          INSTR_CYCLES    = (INSTR_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [1:0]  WRITE_INHIBIT   = 2'h2;
   localparam logic [15:0] WDT_BASE_RESET  = 16'h0000;

   typedef enum logic [1:0] {TPS_IDLE, TPS_ACCESS} tps_bus_state_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } tps_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tps_apb_rsp_t;
endpackage : tps_pkg

//--- tps_prescaler.sv
module tps_prescaler (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clear,
   input  wire logic       tick,
   input  wire logic [3:0] div_log2,
   output logic            out_pulse
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       pulse;
   } tps_ps_state_t;

   tps_ps_state_t st_reg;
   tps_ps_state_t st_next;
   logic [8:0]    wide;

   // ---------------------------------------------------------------
   // shared divider: pulse on every 2^div_log2 input ticks
   // ---------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.pulse = 1'b0;
      wide          = {1'b0, st_reg.cnt} + 9'h001;
      if (clear) begin
         st_next.cnt = 8'h00;
      end else if (tick) begin
         if (div_log2 == 4'h0) begin
            st_next.pulse = 1'b1;
         end else if (wide[div_log2] == 1'b1 && (st_reg.cnt & ((8'h01 << div_log2) - 8'h01))
                      == ((8'h01 << div_log2) - 8'h01)) begin
            st_next.cnt   = 8'h00;
            st_next.pulse = 1'b1;
         end else begin
            st_next.cnt = wide[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign out_pulse = st_reg.pulse;
endmodule : tps_prescaler

//--- tps_timer0.sv
// Contract
// - timer mode counts instruction cycles
// - write to count inhibits two cycles
// - counter mode counts external pin edges
// - edge bit: clear rising, set falling
// - external input synchronised before counting
// - one prescaler, timer or watchdog only
// - prescaler count never software visible
// - option low nibble sets assignment, ratio
// - timer ratios 1:2 to 1:256
// - watchdog ratios 1:1 to 1:128
// - count write clears timer prescaler
// - clear watchdog clears watchdog prescaler
// - wrap sets sticky flag, enabled interrupt
// - counter stops during sleep
//
// Decided for this implementation: the APB interface to the registers.
module tps_timer0 (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_count_pin,
   input  wire logic        wdt_tick,
   output logic             wdt_postscaled,
   output logic             irq
);
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [7:0]  tick_count;
      logic [7:0]  option_control;
      logic        overflow_flag;
      logic        overflow_irq_enable;
      logic [1:0]  control;
      logic [1:0]  inhibit;
      logic [7:0]  icyc;
      logic        sync1;
      logic        sync2;
      logic        sync3;
      logic        irq;
      logic        wdt_out;
   } tps_state_t;

   tps_state_t st_reg;
   tps_state_t st_next;
   logic       ps_clear;
   logic       ps_tick;
   logic [3:0] ps_log2;
   logic       ps_pulse;
   logic       instr_tick;
   logic       src_tick;
   logic       inc;
   logic       acc;
   logic       wr;
   logic       cnt_wr;
   logic       clear_watchdog_instr;
   logic       assign_wdt;
   logic       ovf_set;

   function automatic logic [31:0] tps_zext8(input logic [7:0] v);
      tps_zext8 = {24'h000000, v};
   endfunction : tps_zext8

   // ---------------------------------------------------------------
   // source and prescaler routing
   // ---------------------------------------------------------------
   always_comb begin
      acc        = psel && penable;
      wr         = acc && pwrite;
      cnt_wr     = wr && (paddr == tps_pkg::ADDR_TICK_COUNT);
      clear_watchdog_instr     = st_reg.control[tps_pkg::CTRL_CLEAR_WATCHDOG_INSTR_POS];
      assign_wdt = st_reg.option_control[tps_pkg::OPT_ASSIGN_POS];
      instr_tick = (st_reg.icyc == 8'(tps_pkg::INSTR_CYCLES - 1));
      if (st_reg.option_control[tps_pkg::OPT_SRC_POS]) begin
         if (st_reg.option_control[tps_pkg::OPT_EDGE_POS]) begin
            src_tick = st_reg.sync3 && !st_reg.sync2;
         end else begin
            src_tick = !st_reg.sync3 && st_reg.sync2;
         end
      end else begin
         src_tick = instr_tick;
      end
      if (assign_wdt) begin
         ps_tick  = wdt_tick;
         ps_log2  = {1'b0, st_reg.option_control[2:0]};
         ps_clear = clear_watchdog_instr;
         inc      = src_tick;
      end else begin
         ps_tick  = src_tick && !st_reg.control[tps_pkg::CTRL_SLEEP_POS];
         ps_log2  = {1'b0, st_reg.option_control[2:0]} + 4'h1;
         ps_clear = cnt_wr;
         inc      = ps_pulse;
      end
   end

   tps_prescaler u_ps (
      .pclk      (pclk),
      .presetn   (presetn),
      .clear     (ps_clear),
      .tick      (ps_tick),
      .div_log2  (ps_log2),
      .out_pulse (ps_pulse)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next         = st_reg;
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.control[tps_pkg::CTRL_CLEAR_WATCHDOG_INSTR_POS] = 1'b0;
      ovf_set         = 1'b0;
      st_next.icyc    = instr_tick ? 8'h00 : st_reg.icyc + 8'h01;
      st_next.sync1   = ext_count_pin;
      st_next.sync2   = st_reg.sync1;
      st_next.sync3   = st_reg.sync2;
      st_next.wdt_out = assign_wdt ? ps_pulse : wdt_tick;

      if (st_reg.inhibit != 2'h0 && instr_tick) begin
         st_next.inhibit = st_reg.inhibit - 2'h1;
      end

      if (inc && st_reg.inhibit == 2'h0 && !st_reg.control[tps_pkg::CTRL_SLEEP_POS]) begin
         st_next.tick_count = st_reg.tick_count + 8'h01;
         if (st_reg.tick_count == 8'hFF) begin
            st_next.overflow_flag = 1'b1;
            ovf_set               = 1'b1;
         end
      end

      if (acc && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h00000000;
         case (paddr)
            tps_pkg::ADDR_TICK_COUNT: begin
               st_next.prdata = tps_zext8(st_reg.tick_count);
               if (pwrite) begin
                  st_next.tick_count = pwdata[7:0];
                  st_next.inhibit    = tps_pkg::WRITE_INHIBIT;
               end
            end
            tps_pkg::ADDR_OPTION: begin
               st_next.prdata = tps_zext8(st_reg.option_control);
               if (pwrite) begin
                  st_next.option_control = pwdata[7:0];
               end
            end
            tps_pkg::ADDR_IRQ_STATUS: begin
               st_next.prdata = {31'h0, st_reg.overflow_flag};
            end
            tps_pkg::ADDR_IRQ_ENABLE: begin
               st_next.prdata = {31'h0, st_reg.overflow_irq_enable};
               if (pwrite) begin
                  st_next.overflow_irq_enable = pwdata[0];
               end
            end
            tps_pkg::ADDR_IRQ_CLEAR: begin
               // set wins over clear
               if (pwrite && pwdata[0] && !ovf_set) begin
                  st_next.overflow_flag = 1'b0;
               end
            end
            tps_pkg::ADDR_CONTROL: begin
               st_next.prdata = {30'h0, st_reg.control[1], st_reg.control[0]};
               if (pwrite) begin
                  st_next.control = pwdata[1:0];
               end
            end
            default: begin
               st_next.pslverr = 1'b1;
            end
         endcase
      end
      st_next.irq = st_next.overflow_flag && st_next.overflow_irq_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg                <= '0;
         st_reg.option_control <= tps_pkg::OPTION_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata         = st_reg.prdata;
   assign pready         = st_reg.pready;
   assign pslverr        = st_reg.pslverr;
   assign irq            = st_reg.irq;
   assign wdt_postscaled = st_reg.wdt_out;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(st_reg.tick_count) == 8'hFF && st_reg.tick_count == 8'h00 && !$past(cnt_wr))
      |-> st_reg.overflow_flag)
      else $error("wrap did not set flag");
   a_inhibit_hold: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_wr && !st_reg.pready |=> st_reg.inhibit == 2'h2)
      else $error("count write did not start inhibit");
   a_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.control[0] && !cnt_wr |=> $stable(st_reg.tick_count))
      else $error("count moved in sleep");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == $past(st_next.overflow_flag && st_next.overflow_irq_enable))
      else $error("irq mismatch");
   a_ps_clear: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_wr && !assign_wdt |=> !ps_pulse)
      else $error("prescaler not cleared");
   a_pready_one: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready too long");
   a_timer_src: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.option_control[5] |-> src_tick == instr_tick)
      else $error("timer source wrong");
   a_wdt_route: assert property (@(posedge pclk) disable iff (!presetn)
      !assign_wdt |=> wdt_postscaled == $past(wdt_tick))
      else $error("watchdog not unscaled");

   // ---------------------------------------------------------------
   // assertions: bus and control pulses
   // ---------------------------------------------------------------
   a_pready_wait: assert property (@(posedge pclk) disable iff (!presetn)
      acc && !pready |=> pready)
      else $error("access not answered after one wait state");

   a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
      acc && !pready && !pwrite && paddr == tps_pkg::ADDR_TICK_COUNT
      |=> prdata == {24'h000000, $past(st_reg.tick_count)})
      else $error("count read data wrong");

   a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");

   a_slverr_pair: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");

   a_clear_watchdog_instr_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      clear_watchdog_instr |=> !clear_watchdog_instr)
      else $error("clear watchdog not a pulse");

   // ---------------------------------------------------------------
   // assertions: counting
   // ---------------------------------------------------------------
   a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      !cnt_wr |=> st_reg.tick_count == $past(st_reg.tick_count)
                  || st_reg.tick_count == $past(st_reg.tick_count) + 8'h01)
      else $error("count moved by more than one");

   a_inhibit_block: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.inhibit != 2'h0 && !cnt_wr |=> $stable(st_reg.tick_count))
      else $error("count moved while inhibited");

   a_inhibit_step: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.inhibit != 2'h0 && !instr_tick && !cnt_wr |=> $stable(st_reg.inhibit))
      else $error("inhibit moved between instruction cycles");

   a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn, 3) |-> st_reg.sync3 == $past(ext_count_pin, 3))
      else $error("pin sync delay wrong");

   a_timer_clock: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.option_control[tps_pkg::OPT_SRC_POS] && assign_wdt && !instr_tick && !cnt_wr
      |=> $stable(st_reg.tick_count))
      else $error("timer moved off an instruction cycle");

   a_edge_rise: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.option_control[5:4] == 2'h2 && assign_wdt && st_reg.sync3 && !cnt_wr
      |=> $stable(st_reg.tick_count))
      else $error("count without rising edge");

   a_edge_fall: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.option_control[5:4] == 2'h3 && assign_wdt && !st_reg.sync3 && !cnt_wr
      |=> $stable(st_reg.tick_count))
      else $error("count without falling edge");

   a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.overflow_flag && !(wr && paddr == tps_pkg::ADDR_IRQ_CLEAR)
      |=> st_reg.overflow_flag)
      else $error("overflow flag dropped without clear");

   // ---------------------------------------------------------------
   // assertions: prescaler
   // ---------------------------------------------------------------
   a_wdt_ratio_one: assert property (@(posedge pclk) disable iff (!presetn)
      assign_wdt && st_reg.option_control[2:0] == 3'h0 && wdt_tick && !clear_watchdog_instr |=> ps_pulse)
      else $error("watchdog 1:1 tick lost");

   a_timer_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !assign_wdt && !ps_pulse && !cnt_wr |=> $stable(st_reg.tick_count))
      else $error("count moved without prescaler pulse");
endmodule : tps_timer0

//--- tps_ext_source.sv
module tps_ext_source #(
   parameter int HOLD_CYC = 5
) (
   input  logic pclk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pin = 1'b0;

   // each level is held well over two pclk periods so the sync can see it
   task automatic pulses(input int n, input int hold);
      repeat (n) begin
         repeat (hold) @(posedge pclk);
         pin <= 1'b1;
         repeat (hold) @(posedge pclk);
         pin <= 1'b0;
      end
   endtask : pulses

   task automatic level(input logic v);
      repeat (HOLD_CYC) @(posedge pclk);
      pin <= v;
   endtask : level
endmodule : tps_ext_source

//--- tb_timer0_shared_prescaler.sv
module tb_timer0_shared_prescaler;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, wdt_tick;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        pready, pslverr, ev, ext_pin, wdt_post, irq;
   int          num_errors, n_checks, post_seen, base;

   tps_timer0 tps_timer0_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_pin(ext_pin), .wdt_tick(wdt_tick),
      .wdt_postscaled(wdt_post), .irq(irq));

   tps_ext_source tps_ext_source_inst (.pclk(pclk), .pin(ext_pin));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk) if (wdt_post === 1'b1) post_seen++;

   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic chkr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
      n_checks++;
      if ($isunknown(g) || g < lo || g > hi) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h..%h", $time, g, lo, hi);
      end
   endtask : chkr

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic wtick(input int n);
      repeat (n) begin
         @(posedge pclk);
         wdt_tick <= 1'b1;
         @(posedge pclk);
         wdt_tick <= 1'b0;
      end
   endtask : wtick

   task automatic rd_tick(input logic [31:0] e);
      cyc(10);
      apb(1'b0, tps_pkg::ADDR_TICK_COUNT, 32'h0);
      chk(rv, e);
   endtask : rd_tick

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      apb(1'b0, tps_pkg::ADDR_OPTION, 32'h0);
      chk(rv, 32'h000000FF);
      apb(1'b0, tps_pkg::ADDR_TICK_COUNT, 32'h0);
      chk(rv, 32'h00000000);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, ev}, 32'h00000001);
   endtask : t_reset

   task automatic t_counter;
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000038);
      apb(1'b1, tps_pkg::ADDR_TICK_COUNT, 32'h00000000);
      cyc(100);
      tps_ext_source_inst.level(1'b1);
      rd_tick(32'h00000000);
      tps_ext_source_inst.level(1'b0);
      rd_tick(32'h00000001);
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000028);
      tps_ext_source_inst.level(1'b1);
      rd_tick(32'h00000002);
      tps_ext_source_inst.level(1'b0);
      rd_tick(32'h00000002);
      tps_ext_source_inst.pulses(5, 12);
      rd_tick(32'h00000007);
   endtask : t_counter

   task automatic t_timer;
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000008);
      apb(1'b1, tps_pkg::ADDR_TICK_COUNT, 32'h00000000);
      cyc(400);
      apb(1'b0, tps_pkg::ADDR_TICK_COUNT, 32'h0);
      chkr(rv, 32'h7, 32'h9);
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000000);
      apb(1'b1, tps_pkg::ADDR_TICK_COUNT, 32'h00000000);
      cyc(400);
      apb(1'b0, tps_pkg::ADDR_TICK_COUNT, 32'h0);
      chkr(rv, 32'h3, 32'h5);
   endtask : t_timer

   task automatic t_irq;
      int k;
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000008);
      apb(1'b1, tps_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
      apb(1'b1, tps_pkg::ADDR_TICK_COUNT, 32'h000000FD);
      for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge pclk);
      chk({31'h0, irq}, 32'h00000001);
      apb(1'b0, tps_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rv, 32'h00000001);
      apb(1'b1, tps_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
      cyc(2);
      chk({31'h0, irq}, 32'h00000000);
      apb(1'b1, tps_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
      apb(1'b1, tps_pkg::ADDR_IRQ_CLEAR, 32'h00000001);
      apb(1'b0, tps_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rv, 32'h00000000);
      chk({31'h0, irq}, 32'h00000000);
   endtask : t_irq

   task automatic t_sleep;
      logic [31:0] a;
      apb(1'b1, tps_pkg::ADDR_CONTROL, 32'h00000001);
      apb(1'b0, tps_pkg::ADDR_TICK_COUNT, 32'h0);
      a = rv;
      cyc(200);
      apb(1'b0, tps_pkg::ADDR_TICK_COUNT, 32'h0);
      chk(rv, a);
      apb(1'b1, tps_pkg::ADDR_CONTROL, 32'h00000000);
   endtask : t_sleep

   task automatic t_wdt;
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h0000000A);
      apb(1'b1, tps_pkg::ADDR_CONTROL, 32'h00000002);
      base = post_seen;
      wtick(8);
      cyc(10);
      chk(32'(post_seen - base), 32'h00000002);
      wtick(3);
      apb(1'b1, tps_pkg::ADDR_CONTROL, 32'h00000002);
      base = post_seen;
      wtick(3);
      cyc(10);
      chk(32'(post_seen - base), 32'h00000000);
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000008);
      base = post_seen;
      wtick(3);
      cyc(10);
      chk(32'(post_seen - base), 32'h00000003);
      apb(1'b1, tps_pkg::ADDR_OPTION, 32'h00000002);
      base = post_seen;
      wtick(3);
      cyc(10);
      chk(32'(post_seen - base), 32'h00000003);
   endtask : t_wdt

   task automatic t_rerun;
      @(posedge pclk);
      presetn <= 1'b0;
      cyc(4);
      presetn <= 1'b1;
      apb(1'b0, tps_pkg::ADDR_OPTION, 32'h0);
      chk(rv, 32'h000000FF);
      chk({31'h0, irq}, 32'h00000000);
   endtask : t_rerun

   task automatic summarize;
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      summarize;
   end

   initial begin
      {psel, penable, pwrite, wdt_tick, presetn} = '0;
      paddr = '0;
      pwdata = '0;
      {num_errors, n_checks, post_seen, base} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_counter;
      t_timer;
      t_irq;
      t_sleep;
      t_wdt;
      t_rerun;
      summarize;
   end
endmodule : tb_timer0_shared_prescaler
